//--- rtl/dtc_delay_line.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------------------
// Variable tap delay line for the termination pin
// --------------------------------------------------------------
module dtc_delay_line
    import dtc_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       bit_in,
    input  wire logic [5:0] tap_in,
    output logic            bit_out
);
    logic [DTC_DLY_DEPTH-1:0] line_r;
    logic [DTC_DLY_DEPTH-1:0] line_nxt;

    // Shift one stage per cycle
    always_comb begin
        line_nxt = {line_r[DTC_DLY_DEPTH-2:0], bit_in};
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            line_r <= '0;
        end else begin
            line_r <= line_nxt;
        end
    end

    // Tap zero is the sample taken on the last edge
    assign bit_out = line_r[tap_in];
endmodule : dtc_delay_line
`default_nettype wire

//--- rtl/dtc_pkg.sv
package dtc_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] DTC_ADDR_MODE_ONE   = 8'h00; // mode_register_one image
    localparam logic [7:0] DTC_ADDR_MODE_TWO   = 8'h01; // Dynamic termination, preamble, CRC, chop
    localparam logic [7:0] DTC_ADDR_MODE_FIVE  = 8'h02; // mode_register_five image
    localparam logic [7:0] DTC_ADDR_LATENCY    = 8'h03; // Column, additive, parity latency
    localparam logic [7:0] DTC_ADDR_STATUS     = 8'h04; // Termination state, read only

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int DTC_M1_DLL_EN_BIT    = 0;  // Bit zero: delay-locked loop enable
    localparam int DTC_M5_BUF_DIS_BIT   = 5;  // Bit five: input buffer disable in power down
    localparam int DTC_M2_DYN_EN_BIT    = 0;
    localparam int DTC_M2_PRE2_BIT      = 1;  // Two-cycle preamble
    localparam int DTC_M2_CRC_BIT       = 2;
    localparam int DTC_M2_CHOP_BIT      = 3;  // Fixed four-beat chop
    localparam int DTC_LAT_CWL_LSB      = 0;
    localparam int DTC_LAT_AL_LSB       = 8;
    localparam int DTC_LAT_PL_LSB       = 16;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [31:0] DTC_RST_MODE_ONE  = 32'h0000_0001;
    localparam logic [31:0] DTC_RST_MODE_TWO  = 32'h0000_0000;
    localparam logic [31:0] DTC_RST_MODE_FIVE = 32'h0000_0000;
    localparam logic [31:0] DTC_RST_LATENCY   = 32'h0000_0009;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int DTC_CLK_PERIOD_PS      = 10000;
    localparam int DTC_ASYNC_MIN_PS       = 1000;  // 1.0 ns least delay
    localparam int DTC_ASYNC_MAX_PS       = 9000;  // 9.0 ns longest delay
    localparam int DTC_ASYNC_MIN_CYC_I    = (DTC_ASYNC_MIN_PS + DTC_CLK_PERIOD_PS - 1) / DTC_CLK_PERIOD_PS;
    localparam int DTC_ASYNC_MAX_CYC_I    = DTC_ASYNC_MAX_PS / DTC_CLK_PERIOD_PS;
    // Longest bound rounds down to zero cycles; one cycle is the floor
    localparam int DTC_ASYNC_CYC          = (DTC_ASYNC_MAX_CYC_I < 1) ? 1 : DTC_ASYNC_MAX_CYC_I;
    localparam int DTC_PRE1_ON_SUB        = 2;
    localparam int DTC_PRE2_ON_SUB        = 3;
    localparam int DTC_OFF_CHOP_ADD       = 2;
    localparam int DTC_OFF_BURST_ADD      = 4;
    localparam int DTC_OFF_CRC_ADD        = 5;
    localparam int DTC_LEAD_SUB           = 1;
    localparam int DTC_DLY_DEPTH          = 64;   // Pipeline length for pin latency

    // --------------------------------------------------------------
    // Termination selection
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        DTC_TERM_PARK,
        DTC_TERM_NOM,
        DTC_TERM_WR
    } dtc_term_e;
endpackage : dtc_pkg

//--- rtl/dtc_term_ctrl.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module dtc_term_ctrl
    import dtc_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        term_pin_in,
    input  wire logic        clk_enable_in,
    input  wire logic        write_cmd_in,
    input  wire logic        write_chop_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    output logic [1:0]       term_sel_out,
    output logic             async_mode_out
);
    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [31:0] mode_one_r, mode_one_nxt;
    logic [31:0] mode_two_r, mode_two_nxt;
    logic [31:0] mode_five_r, mode_five_nxt;
    logic [31:0] latency_r, latency_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic [7:0]  write_latency;
    logic        async_mode;
    logic        dyn_en;
    logic        buf_dis;

    assign async_mode    = ~mode_one_r[DTC_M1_DLL_EN_BIT];
    assign dyn_en        = mode_two_r[DTC_M2_DYN_EN_BIT] & ~async_mode;
    assign buf_dis       = mode_five_r[DTC_M5_BUF_DIS_BIT];
    assign write_latency = latency_r[DTC_LAT_CWL_LSB +: 8] + latency_r[DTC_LAT_AL_LSB +: 8]
                         + latency_r[DTC_LAT_PL_LSB +: 8];

    // Register writes and read data; unmapped reads return zero
    always_comb begin
        mode_one_nxt  = mode_one_r;
        mode_two_nxt  = mode_two_r;
        mode_five_nxt = mode_five_r;
        latency_nxt   = latency_r;
        rdata_nxt     = 32'h0000_0000;
        if (wr_in) begin
            unique case (addr_in)
                DTC_ADDR_MODE_ONE:  mode_one_nxt  = wdata_in;
                DTC_ADDR_MODE_TWO:  mode_two_nxt  = wdata_in;
                DTC_ADDR_MODE_FIVE: mode_five_nxt = wdata_in;
                DTC_ADDR_LATENCY:   latency_nxt   = wdata_in;
                default: ;
            endcase
        end
        if (rd_in) begin
            unique case (addr_in)
                DTC_ADDR_MODE_ONE:  rdata_nxt = mode_one_r;
                DTC_ADDR_MODE_TWO:  rdata_nxt = mode_two_r;
                DTC_ADDR_MODE_FIVE: rdata_nxt = mode_five_r;
                DTC_ADDR_LATENCY:   rdata_nxt = latency_r;
                DTC_ADDR_STATUS:    rdata_nxt = {29'h0, async_mode_out, term_sel_out};
                default:            rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            mode_one_r  <= DTC_RST_MODE_ONE;
            mode_two_r  <= DTC_RST_MODE_TWO;
            mode_five_r <= DTC_RST_MODE_FIVE;
            latency_r   <= DTC_RST_LATENCY;
            rdata_r     <= 32'h0000_0000;
        end else begin
            mode_one_r  <= mode_one_nxt;
            mode_two_r  <= mode_two_nxt;
            mode_five_r <= mode_five_nxt;
            latency_r   <= latency_nxt;
            rdata_r     <= rdata_nxt;
        end
    end
    assign rdata_out = rdata_r;

    // --------------------------------------------------------------
    // Latency arithmetic
    // --------------------------------------------------------------
    logic [7:0] on_lat;
    logic [7:0] off_lat;
    logic [7:0] lead_lat;
    logic [5:0] pin_tap;
    logic       pre2;
    logic       crc_on;

    assign pre2   = mode_two_r[DTC_M2_PRE2_BIT];
    assign crc_on = mode_two_r[DTC_M2_CRC_BIT];

    // Sums wrap at eight bits; the tap keeps the low six bits, so latencies beyond the line depth are out of range
    always_comb begin
        on_lat   = write_latency - (pre2 ? 8'(DTC_PRE2_ON_SUB) : 8'(DTC_PRE1_ON_SUB));
        lead_lat = write_latency - 8'(DTC_LEAD_SUB);
        if (crc_on) begin
            off_lat = write_latency + 8'(DTC_OFF_CRC_ADD);
        end else if (write_chop_in | mode_two_r[DTC_M2_CHOP_BIT]) begin
            off_lat = write_latency + 8'(DTC_OFF_CHOP_ADD);
        end else begin
            off_lat = write_latency + 8'(DTC_OFF_BURST_ADD);
        end
        pin_tap = (on_lat == 8'h00) ? 6'h00 : 6'(on_lat - 8'h01);
    end

    // Pin delayed by the direct on/off latency for synchronous mode
    logic pin_late;
    dtc_delay_line u_pin_line (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .bit_in   (term_pin_in),
        .tap_in   (pin_tap),
        .bit_out  (pin_late)
    );

    // --------------------------------------------------------------
    // Write window and power-down tracking
    // --------------------------------------------------------------
    logic [7:0] wr_cnt_r, wr_cnt_nxt;
    logic [7:0] wr_on_r, wr_on_nxt;
    logic [7:0] wr_off_r, wr_off_nxt;
    logic       wr_busy_r, wr_busy_nxt;
    logic       pd_r, pd_nxt;
    logic [7:0] lead_cnt_r, lead_cnt_nxt;
    logic       pin_blk_r, pin_blk_nxt;
    logic       wr_active;

    // A new write restarts the window; back-to-back writes drop what remains of the earlier one
    always_comb begin
        wr_cnt_nxt  = wr_cnt_r;
        wr_on_nxt   = wr_on_r;
        wr_off_nxt  = wr_off_r;
        wr_busy_nxt = wr_busy_r;
        if (write_cmd_in && dyn_en) begin
            wr_cnt_nxt  = 8'h01;
            wr_on_nxt   = on_lat;
            wr_off_nxt  = off_lat;
            wr_busy_nxt = 1'b1;
        end else if (wr_busy_r) begin
            wr_cnt_nxt  = wr_cnt_r + 8'h01;
            wr_busy_nxt = (wr_cnt_r < wr_off_r);
        end
        pd_nxt = ~clk_enable_in;
        // Lead window reloaded through power down and counted down from exit: pin_blk_r held for lead latency, yet it masks the pin only while pd_r is set
        if (~clk_enable_in && buf_dis) begin
            lead_cnt_nxt = lead_lat;
        end else if (lead_cnt_r != 8'h00) begin
            lead_cnt_nxt = lead_cnt_r - 8'h01;
        end else begin
            lead_cnt_nxt = 8'h00;
        end
        pin_blk_nxt = buf_dis & (~clk_enable_in | (lead_cnt_r != 8'h00));
    end

    assign wr_active = wr_busy_r && (wr_cnt_r >= wr_on_r) && (wr_cnt_r < wr_off_r);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_cnt_r   <= 8'h00;
            wr_on_r    <= 8'h00;
            wr_off_r   <= 8'h00;
            wr_busy_r  <= 1'b0;
            pd_r       <= 1'b0;
            lead_cnt_r <= 8'h00;
            pin_blk_r  <= 1'b0;
        end else begin
            wr_cnt_r   <= wr_cnt_nxt;
            wr_on_r    <= wr_on_nxt;
            wr_off_r   <= wr_off_nxt;
            wr_busy_r  <= wr_busy_nxt;
            pd_r       <= pd_nxt;
            lead_cnt_r <= lead_cnt_nxt;
            pin_blk_r  <= pin_blk_nxt;
        end
    end

    // --------------------------------------------------------------
    // Termination selection
    // --------------------------------------------------------------
    dtc_term_e term_r, term_nxt;
    logic      async_r;
    logic      nom_req;

    // Async mode follows the pin after one cycle, 10 ns, beyond the 1.0 to 9.0 ns band
    always_comb begin
        if (async_mode) begin
            nom_req = term_pin_in;
        end else begin
            nom_req = pin_late;
        end
        if (pin_blk_r && pd_r) begin
            nom_req = 1'b0;
        end
        // Priority chain: write and nominal requests may stand together
        if (wr_active) begin
            term_nxt = DTC_TERM_WR;
        end else if (nom_req) begin
            term_nxt = DTC_TERM_NOM;
        end else begin
            term_nxt = DTC_TERM_PARK;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            term_r  <= DTC_TERM_PARK;
            async_r <= 1'b0;
        end else begin
            term_r  <= term_nxt;
            async_r <= async_mode;
        end
    end
    assign term_sel_out   = term_r;
    assign async_mode_out = async_r;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    AST_ASYNC_ON: assert property (@(posedge clock_in) disable iff (rst_in)
        (async_mode && $past(async_mode) && term_pin_in && !wr_active && !(pin_blk_r && pd_r))
        |=> (term_sel_out == DTC_TERM_NOM))
        else $error("async nominal not reached in time");
    AST_ASYNC_OFF: assert property (@(posedge clock_in) disable iff (rst_in)
        (async_mode && !term_pin_in && !wr_active) |=> (term_sel_out == DTC_TERM_PARK))
        else $error("async park not reached in time");
    AST_ASYNC_SEL: assert property (@(posedge clock_in) disable iff (rst_in)
        async_mode_out == !$past(mode_one_r[DTC_M1_DLL_EN_BIT]))
        else $error("async mode does not follow loop enable");
    AST_WR_PRIO: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_active |=> (term_sel_out == DTC_TERM_WR))
        else $error("write termination lost priority");
    AST_WR_ON: assert property (@(posedge clock_in) disable iff (rst_in)
        (write_cmd_in && dyn_en && !pre2 && !crc_on && write_latency > 8'd3 && write_latency < 8'd40)
        ##1 (!write_cmd_in)[*1] |-> (term_sel_out != DTC_TERM_WR))
        else $error("write termination too early");
    AST_WR_SUM: assert property (@(posedge clock_in) disable iff (rst_in)
        write_cmd_in && dyn_en |=> wr_off_r == 8'($past(write_latency)
            + ($past(crc_on) ? DTC_OFF_CRC_ADD
            : $past(write_chop_in | mode_two_r[DTC_M2_CHOP_BIT]) ? DTC_OFF_CHOP_ADD : DTC_OFF_BURST_ADD)))
        else $error("off latency not derived from sum");
    AST_PD_BLOCK: assert property (@(posedge clock_in) disable iff (rst_in)
        (buf_dis && !clk_enable_in && $past(!clk_enable_in) && !wr_active && $past(buf_dis))
        |=> (term_sel_out != DTC_TERM_NOM))
        else $error("nominal termination in power down");
    AST_NO_DYN: assert property (@(posedge clock_in) disable iff (rst_in)
        (!wr_busy_r) |=> (term_sel_out != DTC_TERM_WR))
        else $error("write termination without write");
endmodule : dtc_term_ctrl
`default_nettype wire

//--- test/dtc_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// Memory controller: termination pin, clock enable, writes
// ----------------------------------------------------------
module dtc_ctrl_model (
    input  wire logic clock_in,
    output logic      term_pin_out,
    output logic      clk_enable_out,
    output logic      write_cmd_out,
    output logic      write_chop_out
);
    // Idle controller: pin low, device awake, no command
    initial begin
        term_pin_out   = 1'b0;
        clk_enable_out = 1'b1;
        write_cmd_out  = 1'b0;
        write_chop_out = 1'b0;
    end

    // One-cycle write; chop flips after so the device cannot lean on it
    task automatic write(input logic chop);
        @(posedge clock_in);
        write_cmd_out  <= 1'b1;
        write_chop_out <= chop;
        @(posedge clock_in);
        write_cmd_out  <= 1'b0;
        write_chop_out <= ~chop;
    endtask

    task automatic pin(input logic v);
        @(posedge clock_in);
        term_pin_out <= v;
    endtask

    // Pin is left steady through entry; this model never floats it
    task automatic pd_enter();
        @(posedge clock_in);
        clk_enable_out <= 1'b0;
    endtask

    // Pin is driven low together with clock enable going high
    task automatic pd_exit();
        @(posedge clock_in);
        clk_enable_out <= 1'b1;
        term_pin_out   <= 1'b0;
    endtask
endmodule // dtc_ctrl_model
`default_nettype wire

//--- test/dtc_term_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dtc_term_ctrl_tb_top;
    import dtc_pkg::*;
    logic        clock_in;
    logic        rst_in;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  term_sel;
    logic        async_mode;
    logic        pin;
    logic        cke;
    logic        cmd;
    logic        chop;
    int          failures;
    int          checked;

    // ----------------------------------------------------------
    // Device and controller
    // ----------------------------------------------------------
    dtc_ctrl_model ctrl (.clock_in(clock_in), .term_pin_out(pin), .clk_enable_out(cke),
                         .write_cmd_out(cmd), .write_chop_out(chop));
    dtc_term_ctrl dut (.clock_in(clock_in), .rst_in(rst_in), .term_pin_in(pin), .clk_enable_in(cke),
                       .write_cmd_in(cmd), .write_chop_in(chop), .addr_in(addr), .wdata_in(wdata),
                       .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .term_sel_out(term_sel),
                       .async_mode_out(async_mode));

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        @(negedge clock_in);
        d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    task automatic conclude();
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        logic [31:0] v;
        reg_rd(DTC_ADDR_MODE_ONE, v);  check(v, DTC_RST_MODE_ONE);
        reg_rd(DTC_ADDR_MODE_TWO, v);  check(v, DTC_RST_MODE_TWO);
        reg_rd(DTC_ADDR_MODE_FIVE, v); check(v, DTC_RST_MODE_FIVE);
        reg_rd(DTC_ADDR_LATENCY, v);   check(v, DTC_RST_LATENCY);
        reg_rd(DTC_ADDR_STATUS, v);    check(v, 32'h0000_0000);
        reg_wr(8'h10, 32'hFFFF_FFFF);
        reg_rd(8'h10, v);              check(v, 32'h0000_0000);
    endtask

    // Write window per latency, preamble, crc and chop; edge c0 = command taken,
    // write termination shows from edge c0+on until edge c0+off takes it away
    task automatic t_dynamic();
        logic [31:0] lat [5] = '{32'h09, 32'h09, 32'h09, 32'h09, 32'h0001_0209};
        logic [31:0] m2  [5] = '{32'h1, 32'h1, 32'h9, 32'h5, 32'h3};
        logic        ch  [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        int wl, on, off, first, last;
        for (int i = 0; i < 5; i++) begin
            reg_wr(DTC_ADDR_LATENCY, lat[i]);
            reg_wr(DTC_ADDR_MODE_TWO, m2[i]);
            wl  = lat[i][7:0] + lat[i][15:8] + lat[i][23:16];
            on  = wl - (m2[i][DTC_M2_PRE2_BIT] ? DTC_PRE2_ON_SUB : DTC_PRE1_ON_SUB);
            off = wl + (m2[i][DTC_M2_CRC_BIT] ? DTC_OFF_CRC_ADD :
                  (ch[i] | m2[i][DTC_M2_CHOP_BIT]) ? DTC_OFF_CHOP_ADD : DTC_OFF_BURST_ADD);
            ctrl.write(ch[i]);
            first = -1;
            last  = -1;
            for (int k = 0; k < 30; k++) begin
                @(negedge clock_in);
                if (term_sel === DTC_TERM_WR) begin
                    if (first < 0) first = k;
                    last = k;
                end
            end
            check(32'(first), 32'(on));
            check(32'(last), 32'(off - 1));
        end
        reg_wr(DTC_ADDR_LATENCY, DTC_RST_LATENCY);
    endtask

    // Pin high with a write on top; mode_two still has dynamic enabled
    task automatic t_overlap();
        ctrl.pin(1'b1);
        settle(12);
        check(32'(term_sel), 32'(DTC_TERM_NOM));
        ctrl.write(1'b0);
        settle(10);
        check(32'(term_sel), 32'(DTC_TERM_WR));
        settle(10);
        check(32'(term_sel), 32'(DTC_TERM_NOM));
        ctrl.pin(1'b0);
        settle(12);
        check(32'(term_sel), 32'(DTC_TERM_PARK));
    endtask

    // Loop off: pin reaches the output at the first edge that samples it, additive latency ignored
    task automatic t_async();
        logic [31:0] v;
        reg_wr(DTC_ADDR_LATENCY, 32'h0000_1009);
        reg_wr(DTC_ADDR_MODE_ONE, 32'h0);
        settle(2);
        check(32'(async_mode), 32'h1);
        ctrl.pin(1'b1);
        settle(1);
        check(32'(term_sel), 32'(DTC_TERM_PARK));
        settle(1);
        check(32'(term_sel), 32'(DTC_TERM_NOM));
        reg_rd(DTC_ADDR_STATUS, v);
        check(v, {29'h0, 1'b1, 2'(DTC_TERM_NOM)});
        ctrl.pin(1'b0);
        settle(1);
        check(32'(term_sel), 32'(DTC_TERM_NOM));
        settle(1);
        check(32'(term_sel), 32'(DTC_TERM_PARK));
        reg_wr(DTC_ADDR_MODE_ONE, DTC_RST_MODE_ONE);
        reg_wr(DTC_ADDR_LATENCY, DTC_RST_LATENCY);
        settle(2);
        check(32'(async_mode), 32'h0);
    endtask

    // Buffer disable: nominal withheld while powered down
    task automatic t_powerdown();
        reg_wr(DTC_ADDR_MODE_FIVE, 32'h20);
        ctrl.pin(1'b1);
        settle(12);
        check(32'(term_sel), 32'(DTC_TERM_NOM));
        ctrl.pd_enter();
        settle(12);
        check(32'(term_sel), 32'(DTC_TERM_PARK));
        ctrl.pd_exit();
        settle(12);
        check(32'(term_sel), 32'(DTC_TERM_PARK));
    endtask

    // Reset in mid-run while the pin stands high restores mode one, mode five and latency reset values
    task automatic t_midreset();
        logic [31:0] v;
        reg_wr(DTC_ADDR_LATENCY, 32'h0000_000B);
        reg_wr(DTC_ADDR_MODE_ONE, 32'h0);
        ctrl.pin(1'b1);
        settle(2);
        check(32'(term_sel), 32'(DTC_TERM_NOM));
        @(posedge clock_in);
        rst_in <= 1'b1;
        settle(1);
        check(32'(term_sel), 32'(DTC_TERM_PARK));
        check(32'(async_mode), 32'h0);
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        reg_rd(DTC_ADDR_MODE_ONE, v);  check(v, DTC_RST_MODE_ONE);
        reg_rd(DTC_ADDR_MODE_FIVE, v); check(v, DTC_RST_MODE_FIVE);
        reg_rd(DTC_ADDR_LATENCY, v);   check(v, DTC_RST_LATENCY);
        ctrl.pin(1'b0);
        settle(12);
        check(32'(term_sel), 32'(DTC_TERM_PARK));
    endtask

    // ----------------------------------------------------------
    // Clock, sequence and watchdog
    // ----------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    initial begin
        failures = 0;
        checked  = 0;
        rst_in   = 1'b1;
        wr       = 1'b0;
        rd       = 1'b0;
        addr     = 8'h00;
        wdata    = 32'h0;
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset();
        t_dynamic();
        t_overlap();
        t_async();
        t_powerdown();
        t_midreset();
        conclude();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #100us;
        failures++;
        conclude();
    end
endmodule // dtc_term_ctrl_tb_top
`default_nettype wire
